// ---- rtl/swc_event_counter.sv ----
// Free-running event counter with a compare match pulse, used for wake timers and pulse counters.
`default_nettype none

module swc_event_counter #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         en_i,
  input  wire logic         step_i,
  input  wire logic [W-1:0] target_i,
  output logic      [W-1:0] count_o,
  output logic              hit_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } swc_cnt_state_t;

  swc_cnt_state_t s;
  swc_cnt_state_t next_s;

  always_comb begin
    next_s     = s;
    next_s.hit = 1'b0;
    if (en_i && step_i) begin
      next_s.cnt = s.cnt + {{(W-1){1'b0}}, 1'b1};
      next_s.hit = (next_s.cnt == target_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count_o = s.cnt;
  assign hit_o   = s.hit;

  property p_keeps_counting;
    @(posedge clk_i) disable iff (srst_i)
      (s.hit && en_i && step_i) |=> (s.cnt == $past(s.cnt) + {{(W-1){1'b0}}, 1'b1});
  endproperty
  a_keeps_counting: assert property (p_keeps_counting)
    else $error("Counter stopped after its match.");

  property p_hit_on_match;
    @(posedge clk_i) disable iff (srst_i)
      (en_i && step_i && (s.cnt + {{(W-1){1'b0}}, 1'b1} == target_i)) |=> hit_o;
  endproperty
  a_hit_on_match: assert property (p_hit_on_match)
    else $error("Match pulse missing.");

endmodule

`default_nettype wire

// ---- rtl/swc_sleep_wakeup_controller.sv ----
// Constants package and top module of the sleep and wake-up controller.
`default_nettype none

package swc_pkg;
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned SLOW_HZ   = 32_000;
  localparam int unsigned SLOW_DIV  = CLK_HZ / SLOW_HZ;
  localparam int unsigned DIV_W     = 12;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned NPIN      = 16;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned NTMR      = 2;
  localparam int unsigned NPC       = 2;
  localparam int unsigned TMR_W     = 41;
  localparam int unsigned PC_W      = 16;

  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_POWER      = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_MASK       = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_EDGE       = 8'h10;
  localparam logic [ADDR_W-1:0] REG_T0_CMP_LO  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_T0_CMP_HI  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_T1_CMP_LO  = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_T1_CMP_HI  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_T0_CNT_LO  = 8'h24;
  localparam logic [ADDR_W-1:0] REG_T0_CNT_HI  = 8'h28;
  localparam logic [ADDR_W-1:0] REG_T1_CNT_LO  = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_T1_CNT_HI  = 8'h30;
  localparam logic [ADDR_W-1:0] REG_PC_TARGET  = 8'h34;
  localparam logic [ADDR_W-1:0] REG_PC_COUNT   = 8'h38;

  localparam int unsigned CTRL_FLICK_EN  = 0;
  localparam int unsigned CTRL_FLICK_NOR = 1;
  localparam int unsigned CTRL_FLICK_SEL = 4;
  localparam int unsigned CTRL_OSC_OFF   = 8;
  localparam int unsigned CTRL_DEBOUNCE  = 9;
  localparam int unsigned CTRL_CMP_RISE  = 10;
  localparam int unsigned CTRL_CMP_FALL  = 11;
  localparam int unsigned CTRL_TMR_EN    = 12;
  localparam int unsigned CTRL_PC_EN     = 14;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0C00;

  localparam int unsigned PWR_SLEEP = 0;
  localparam int unsigned PWR_DEEP  = 1;

  localparam int unsigned ST_TMR = 0;
  localparam int unsigned ST_CMP = 2;
  localparam int unsigned ST_PC  = 3;
  localparam int unsigned ST_PIN = 16;
  localparam logic [DATA_W-1:0] STATUS_USED  = 32'hFFFF_001F;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_RESET   = 32'h0000_0000;
  localparam logic [NPIN-1:0]   EDGE_RESET   = 16'hFFFF;

  typedef enum logic [2:0] {
    SWC_ACTIVE = 3'h1,
    SWC_SLEEP  = 3'h2,
    SWC_DEEP   = 3'h4
  } swc_pwr_t;

  function automatic logic swc_sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction
endpackage

module swc_sleep_wakeup_controller #(
  parameter int unsigned TW = swc_pkg::TMR_W,
  parameter int unsigned PW = swc_pkg::PC_W
) (
  input  wire logic                        CLK_I,
  input  wire logic                        SRST_I,
  input  wire logic [swc_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [swc_pkg::DATA_W-1:0]  WR_DATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [swc_pkg::DATA_W-1:0]  RD_DATA_O,
  output logic                             IRQ_O,
  input  wire logic [swc_pkg::NPIN-1:0]    GENERAL_PIN_I,
  output logic      [swc_pkg::NPIN-1:0]    GENERAL_PIN_O,
  output logic      [swc_pkg::NPIN-1:0]    GENERAL_PIN_OE_O,
  input  wire logic                        COMP_I,
  input  wire logic [swc_pkg::NPC-1:0]     PULSE_I,
  input  wire logic                        RESET_PIN_N_I,
  input  wire logic                        RADIO_RX_ACTIVE_I,
  input  wire logic                        RADIO_TX_ACTIVE_I,
  output logic      [2:0]                  POWER_STATE_O,
  output logic                             OSC32_EN_O,
  output logic                             DIGITAL_PWR_EN_O,
  output logic                             BOR_EN_O,
  output logic                             PIN_CELL_EN_O
);
  import swc_pkg::*;

  typedef struct packed {
    swc_pwr_t                   state;
    logic                       flick_en;
    logic                       flick_nor;
    logic [SEL_W-1:0]           flick_sel;
    logic                       osc_off;
    logic                       debounce;
    logic                       cmp_rise;
    logic                       cmp_fall;
    logic [NTMR-1:0]            tmr_en;
    logic [NPC-1:0]             pc_en;
    logic [DATA_W-1:0]          status;
    logic [DATA_W-1:0]          mask;
    logic [NPIN-1:0]            edge_rise;
    logic [NTMR-1:0][TW-1:0]    tmr_cmp;
    logic [NPC-1:0][PW-1:0]     pc_tgt;
    logic [DIV_W-1:0]           div;
    logic                       slow_tick;
    logic [NPIN-1:0]            pin_s1;
    logic [NPIN-1:0]            pin_s2;
    logic [NPIN-1:0]            pin_p;
    logic                       cmp_s1;
    logic                       cmp_s2;
    logic                       cmp_p;
    logic [NPC-1:0]             pul_s1;
    logic [NPC-1:0]             pul_s2;
    logic [NPC-1:0]             pul_p;
    logic [NPC-1:0]             deb;
    logic                       rst_s1;
    logic                       rst_s2;
    logic [DATA_W-1:0]          rd_data;
    logic                       irq;
    logic                       osc_en;
    logic                       dig_pwr;
    logic [NPIN-1:0]            pin_o;
    logic [NPIN-1:0]            pin_oe;
    logic                       bor_en;
    logic                       pin_cell_en;
  } swc_state_t;

  swc_state_t s;
  swc_state_t next_s;

  logic [NTMR-1:0][TW-1:0] tmr_cnt;
  logic [NTMR-1:0]         tmr_hit;
  logic [NPC-1:0][PW-1:0]  pc_cnt;
  logic [NPC-1:0]          pc_hit;
  logic [NPC-1:0]          pc_step;

  // timer 0 for the radio stack, timer 1 for software.
  // the tick runs in sleep whenever the slow clock is kept on.
  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    swc_event_counter #(.W(TW)) u_tmr (
      .clk_i    (CLK_I),
      .srst_i   (SRST_I),
      .en_i     (s.tmr_en[i]),
      .step_i   (s.slow_tick),
      .target_i (s.tmr_cmp[i]),
      .count_o  (tmr_cnt[i]),
      .hit_o    (tmr_hit[i])
    );
  end

  // raw edges need no slow clock; debounce samples on the slow tick.
  for (genvar i = 0; i < NPC; i++) begin : g_pc
    assign pc_step[i] = s.debounce ? (s.slow_tick & s.pul_s2[i] & ~s.deb[i])
                                   : (s.pul_s2[i] & ~s.pul_p[i]);
    swc_event_counter #(.W(PW)) u_pc (
      .clk_i    (CLK_I),
      .srst_i   (SRST_I),
      .en_i     (s.pc_en[i]),
      .step_i   (pc_step[i]),
      .target_i (s.pc_tgt[i]),
      .count_o  (pc_cnt[i]),
      .hit_o    (pc_hit[i])
    );
  end

  always_comb begin
    logic [NPIN-1:0]   pin_ev;
    logic [DATA_W-1:0] set;
    logic [DATA_W-1:0] clr;
    logic              pend_en;
    logic              flick;
    pin_ev  = '0;
    set     = '0;
    clr     = '0;
    pend_en = |(s.status & s.mask);
    flick   = RADIO_RX_ACTIVE_I | RADIO_TX_ACTIVE_I;
    next_s  = s;
    next_s.rd_data   = '0;
    next_s.slow_tick = 1'b0;
    next_s.pin_s1 = GENERAL_PIN_I;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_p  = s.pin_s2;
    next_s.cmp_s1 = COMP_I;
    next_s.cmp_s2 = s.cmp_s1;
    next_s.cmp_p  = s.cmp_s2;
    next_s.pul_s1 = PULSE_I;
    next_s.pul_s2 = s.pul_s1;
    next_s.pul_p  = s.pul_s2;
    next_s.rst_s1 = RESET_PIN_N_I;
    next_s.rst_s2 = s.rst_s1;
    // The divider stops with the oscillator, so timers freeze rather than drift.
    if (!s.osc_en) begin
      next_s.div = '0;
    end else if (s.div == DIV_W'(SLOW_DIV - 1)) begin
      next_s.div       = '0;
      next_s.slow_tick = 1'b1;
    end else begin
      next_s.div = s.div + 12'h001;
    end
    if (s.slow_tick) begin
      next_s.deb = s.pul_s2;
    end
    // raw pad edges, independent of any alternate pin function.
    pin_ev = ((s.edge_rise & s.pin_s2 & ~s.pin_p) | (~s.edge_rise & ~s.pin_s2 & s.pin_p))
             & s.mask[ST_PIN +: NPIN];
    set[ST_PIN +: NPIN] = pin_ev;
    set[ST_TMR +: NTMR] = tmr_hit;
    set[ST_PC +: NPC]   = pc_hit;
    // either comparator direction may be armed.
    set[ST_CMP] = (s.cmp_rise & s.cmp_s2 & ~s.cmp_p) | (s.cmp_fall & ~s.cmp_s2 & s.cmp_p);
    if (WR_I) begin
      if (swc_sel(ADDR_I, REG_CTRL)) begin
        next_s.flick_en  = WR_DATA_I[CTRL_FLICK_EN];
        next_s.flick_nor = WR_DATA_I[CTRL_FLICK_NOR];
        next_s.flick_sel = WR_DATA_I[CTRL_FLICK_SEL +: SEL_W];
        next_s.osc_off   = WR_DATA_I[CTRL_OSC_OFF];
        next_s.debounce  = WR_DATA_I[CTRL_DEBOUNCE];
        next_s.cmp_rise  = WR_DATA_I[CTRL_CMP_RISE];
        next_s.cmp_fall  = WR_DATA_I[CTRL_CMP_FALL];
        next_s.tmr_en    = WR_DATA_I[CTRL_TMR_EN +: NTMR];
        next_s.pc_en     = WR_DATA_I[CTRL_PC_EN +: NPC];
      end else if (swc_sel(ADDR_I, REG_STATUS)) begin
        clr = WR_DATA_I;
      end else if (swc_sel(ADDR_I, REG_MASK)) begin
        next_s.mask = WR_DATA_I & STATUS_USED;
      end else if (swc_sel(ADDR_I, REG_EDGE)) begin
        next_s.edge_rise = WR_DATA_I[NPIN-1:0];
      end else if (swc_sel(ADDR_I, REG_T0_CMP_LO)) begin
        next_s.tmr_cmp[0][31:0] = WR_DATA_I;
      end else if (swc_sel(ADDR_I, REG_T0_CMP_HI)) begin
        next_s.tmr_cmp[0][TW-1:32] = WR_DATA_I[TW-33:0];
      end else if (swc_sel(ADDR_I, REG_T1_CMP_LO)) begin
        next_s.tmr_cmp[1][31:0] = WR_DATA_I;
      end else if (swc_sel(ADDR_I, REG_T1_CMP_HI)) begin
        next_s.tmr_cmp[1][TW-1:32] = WR_DATA_I[TW-33:0];
      end else if (swc_sel(ADDR_I, REG_PC_TARGET)) begin
        next_s.pc_tgt = WR_DATA_I;
      end
    end
    // a new event beats a same-cycle clear.
    next_s.status = ((s.status & ~clr) | set) & STATUS_USED;
    case (s.state)
      SWC_ACTIVE: begin
        if (WR_I && swc_sel(ADDR_I, REG_POWER) && !pend_en) begin
          if (WR_DATA_I[PWR_DEEP]) begin
            next_s.state = SWC_DEEP;
          end else if (WR_DATA_I[PWR_SLEEP]) begin
            next_s.state = SWC_SLEEP;
          end
        end
      end
      SWC_SLEEP: begin
        if (|(next_s.status & next_s.mask)) begin
          next_s.state = SWC_ACTIVE;
        end
      end
      SWC_DEEP: begin
        // reset pin or enabled pin event only.
        if (!s.rst_s2 || (|next_s.status[ST_PIN +: NPIN])) begin
          next_s.state = SWC_ACTIVE;
        end
      end
      default: begin
        next_s.state = SWC_ACTIVE;
      end
    endcase
    // slow clock off in deep sleep, back on at any wake.
    next_s.osc_en  = (next_s.state == SWC_ACTIVE) ||
                     ((next_s.state == SWC_SLEEP) && !s.osc_off);
    next_s.dig_pwr = (next_s.state == SWC_ACTIVE);
    next_s.bor_en      = 1'b1;
    next_s.pin_cell_en = 1'b1;
    // interrupt is the wake request seen by software.
    next_s.irq = |(next_s.status & next_s.mask);
    // OR or NOR of radio activity onto the chosen pin.
    next_s.pin_o  = '0;
    next_s.pin_oe = '0;
    next_s.pin_o[s.flick_sel]  = flick ^ s.flick_nor;
    next_s.pin_oe[s.flick_sel] = s.flick_en;
    if (RD_I) begin
      if (swc_sel(ADDR_I, REG_CTRL)) begin
        next_s.rd_data[CTRL_FLICK_EN]          = s.flick_en;
        next_s.rd_data[CTRL_FLICK_NOR]         = s.flick_nor;
        next_s.rd_data[CTRL_FLICK_SEL +: SEL_W] = s.flick_sel;
        next_s.rd_data[CTRL_OSC_OFF]           = s.osc_off;
        next_s.rd_data[CTRL_DEBOUNCE]          = s.debounce;
        next_s.rd_data[CTRL_CMP_RISE]          = s.cmp_rise;
        next_s.rd_data[CTRL_CMP_FALL]          = s.cmp_fall;
        next_s.rd_data[CTRL_TMR_EN +: NTMR]    = s.tmr_en;
        next_s.rd_data[CTRL_PC_EN +: NPC]      = s.pc_en;
      end else if (swc_sel(ADDR_I, REG_POWER)) begin
        next_s.rd_data[2:0] = s.state;
      end else if (swc_sel(ADDR_I, REG_STATUS)) begin
        next_s.rd_data = s.status;
      end else if (swc_sel(ADDR_I, REG_MASK)) begin
        next_s.rd_data = s.mask;
      end else if (swc_sel(ADDR_I, REG_EDGE)) begin
        next_s.rd_data[NPIN-1:0] = s.edge_rise;
      end else if (swc_sel(ADDR_I, REG_T0_CMP_LO)) begin
        next_s.rd_data = s.tmr_cmp[0][31:0];
      end else if (swc_sel(ADDR_I, REG_T0_CMP_HI)) begin
        next_s.rd_data[TW-33:0] = s.tmr_cmp[0][TW-1:32];
      end else if (swc_sel(ADDR_I, REG_T1_CMP_LO)) begin
        next_s.rd_data = s.tmr_cmp[1][31:0];
      end else if (swc_sel(ADDR_I, REG_T1_CMP_HI)) begin
        next_s.rd_data[TW-33:0] = s.tmr_cmp[1][TW-1:32];
      end else if (swc_sel(ADDR_I, REG_T0_CNT_LO)) begin
        next_s.rd_data = tmr_cnt[0][31:0];
      end else if (swc_sel(ADDR_I, REG_T0_CNT_HI)) begin
        next_s.rd_data[TW-33:0] = tmr_cnt[0][TW-1:32];
      end else if (swc_sel(ADDR_I, REG_T1_CNT_LO)) begin
        next_s.rd_data = tmr_cnt[1][31:0];
      end else if (swc_sel(ADDR_I, REG_T1_CNT_HI)) begin
        next_s.rd_data[TW-33:0] = tmr_cnt[1][TW-1:32];
      end else if (swc_sel(ADDR_I, REG_PC_TARGET)) begin
        next_s.rd_data = s.pc_tgt;
      end else if (swc_sel(ADDR_I, REG_PC_COUNT)) begin
        next_s.rd_data = pc_cnt;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s           <= '0;
      s.state     <= SWC_ACTIVE;
      s.cmp_rise  <= CTRL_RESET[CTRL_CMP_RISE];
      s.cmp_fall  <= CTRL_RESET[CTRL_CMP_FALL];
      s.status    <= STATUS_RESET;
      s.mask      <= MASK_RESET;
      s.edge_rise <= EDGE_RESET;
      s.rst_s1    <= 1'b1;
      s.rst_s2    <= 1'b1;
      s.osc_en    <= 1'b1;
      s.dig_pwr   <= 1'b1;
      s.bor_en    <= 1'b1;
      s.pin_cell_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign RD_DATA_O        = s.rd_data;
  assign IRQ_O            = s.irq;
  assign GENERAL_PIN_O    = s.pin_o;
  assign GENERAL_PIN_OE_O = s.pin_oe;
  assign POWER_STATE_O    = s.state;
  assign OSC32_EN_O       = s.osc_en;
  assign DIGITAL_PWR_EN_O = s.dig_pwr;
  // brown-out and pin cells never switch off, deep sleep included.
  assign BOR_EN_O         = s.bor_en;
  assign PIN_CELL_EN_O    = s.pin_cell_en;

  property p_sleep_refused;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.state == SWC_ACTIVE && WR_I && ADDR_I == REG_POWER && (|(s.status & s.mask)))
      |=> s.state == SWC_ACTIVE;
  endproperty
  a_sleep_refused: assert property (p_sleep_refused)
    else $error("Sleep entered with an enabled flag pending.");

  property p_sleep_wake;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.state == SWC_SLEEP && (|(s.status & s.mask))) |=> s.state == SWC_ACTIVE;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("Enabled pending flag did not wake from sleep.");

  property p_deep_hold;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.state == SWC_DEEP && s.rst_s2 && next_s.status[ST_PIN +: NPIN] == '0)
      |=> s.state == SWC_DEEP;
  endproperty
  a_deep_hold: assert property (p_deep_hold)
    else $error("Deep sleep left without reset pin or pin event.");

  property p_deep_osc_off;
    @(posedge CLK_I) disable iff (SRST_I)
      s.state == SWC_DEEP |-> (!OSC32_EN_O && !DIGITAL_PWR_EN_O) ##1 !s.slow_tick;
  endproperty
  a_deep_osc_off: assert property (p_deep_osc_off)
    else $error("Slow clock or domain running in deep sleep.");

  property p_osc_restart;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.state != SWC_ACTIVE) ##1 (s.state == SWC_ACTIVE)
      |-> OSC32_EN_O ##1 (s.div != '0 || s.slow_tick);
  endproperty
  a_osc_restart: assert property (p_osc_restart)
    else $error("Slow clock not restarted at wake.");

  property p_irq_tracks;
    @(posedge CLK_I) disable iff (SRST_I)
      $rose(|(s.status & s.mask)) |-> IRQ_O;
  endproperty
  a_irq_tracks: assert property (p_irq_tracks)
    else $error("Interrupt not raised for enabled flag.");

  property p_flag_sticky;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.status[ST_CMP] && !(WR_I && ADDR_I == REG_STATUS && WR_DATA_I[ST_CMP]))
      |=> s.status[ST_CMP];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Comparator flag lost without a clear.");

  property p_cmp_event;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.cmp_rise && s.cmp_s2 && !s.cmp_p) |=> s.status[ST_CMP];
  endproperty
  a_cmp_event: assert property (p_cmp_event)
    else $error("Comparator change did not set its flag.");

  property p_flicker;
    @(posedge CLK_I) disable iff (SRST_I)
      s.flick_en |=> (GENERAL_PIN_O[$past(s.flick_sel)] ==
        ($past(s.flick_nor) ^ ($past(RADIO_RX_ACTIVE_I) | $past(RADIO_TX_ACTIVE_I))));
  endproperty
  a_flicker: assert property (p_flicker)
    else $error("Flicker pin does not follow radio activity.");

  property p_pin_event;
    @(posedge CLK_I) disable iff (SRST_I)
      (s.mask[ST_PIN] && s.edge_rise[0] && s.pin_s2[0] && !s.pin_p[0]) |=> s.status[ST_PIN];
  endproperty
  a_pin_event: assert property (p_pin_event)
    else $error("Enabled pin edge did not set its flag.");

endmodule

`default_nettype wire

// ---- verif/swc_far_side.sv ----
// Far-side model: general pins, comparator, pulse inputs, reset pin and radio activity.
`default_nettype none
module swc_far_side (
  input  wire logic                    clk_i,
  output logic [swc_pkg::NPIN-1:0]     pin_o,
  output logic                         comp_o,
  output logic [swc_pkg::NPC-1:0]      pulse_o,
  output logic                         reset_n_o,
  output logic                         rx_o,
  output logic                         tx_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import swc_pkg::*;
  initial begin
    pin_o = '0;
    comp_o = 1'b0;
    pulse_o = '0;
    reset_n_o = 1'b1;
    rx_o = 1'b0;
    tx_o = 1'b0;
  end
  task automatic set_pin(input int k, input logic v);
    @(posedge clk_i) pin_o[k] <= v;
  endtask
  task automatic set_comp(input logic v);
    @(posedge clk_i) comp_o <= v;
  endtask
  task automatic radio(input logic r, input logic t);
    @(posedge clk_i) {rx_o, tx_o} <= {r, t};
  endtask
  // Pulses are held long enough to pass the input synchroniser.
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i) pulse_o[k] <= 1'b1;
      repeat (3) @(posedge clk_i);
      pulse_o[k] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic reset_pin(input int n);
    @(posedge clk_i) reset_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    reset_n_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verif/swc_sleep_wakeup_controller_tb_top.sv ----
// Self-checking testbench of the sleep and wake-up controller.
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: %s", $time, m); end end
module swc_sleep_wakeup_controller_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import swc_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic irq, osc, dpwr, bor, pce;
  logic [15:0] pin, pin_o, pin_oe;
  logic [2:0] pst;
  logic comp, rstn, rx, tx;
  logic [1:0] pls;
  int failures = 0, total_checks = 0;
  swc_far_side far (.clk_i(clk), .pin_o(pin), .comp_o(comp), .pulse_o(pls),
    .reset_n_o(rstn), .rx_o(rx), .tx_o(tx));
  swc_sleep_wakeup_controller uut (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
    .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .IRQ_O(irq),
    .GENERAL_PIN_I(pin), .GENERAL_PIN_O(pin_o), .GENERAL_PIN_OE_O(pin_oe), .COMP_I(comp),
    .PULSE_I(pls), .RESET_PIN_N_I(rstn), .RADIO_RX_ACTIVE_I(rx), .RADIO_TX_ACTIVE_I(tx),
    .POWER_STATE_O(pst), .OSC32_EN_O(osc), .DIGITAL_PWR_EN_O(dpwr), .BOR_EN_O(bor),
    .PIN_CELL_EN_O(pce));
  initial forever #4 clk = ~clk;
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_state(input logic [2:0] s, input int n);
    for (int i = 0; i < n && pst !== s; i++) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    bus_rd(REG_CTRL); `CHK(d, CTRL_RESET, "ctrl")
    bus_rd(REG_EDGE); `CHK(d, 32'h0000_FFFF, "edge")
    bus_rd(REG_STATUS); `CHK(d, STATUS_RESET, "status")
    bus_rd(REG_POWER); `CHK(d, 32'h0000_0001, "power")
    bus_rd(8'hFC); `CHK(d, 32'h0000_0000, "unmapped")
    $display("test reset done");
  endtask
  task automatic t_flicker();
    far.radio(1'b1, 1'b0);
    bus_wr(REG_CTRL, CTRL_RESET | 32'h0000_0031);
    repeat (2) @(posedge clk);
    `CHK({pin_oe, pin_o}, 32'h0008_0008, "flicker or")
    bus_wr(REG_CTRL, CTRL_RESET | 32'h0000_0033);
    far.radio(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    `CHK({pin_oe, pin_o}, 32'h0008_0008, "flicker nor idle")
    bus_wr(REG_CTRL, CTRL_RESET);
    $display("test flicker done");
  endtask
  task automatic t_pin();
    bus_wr(REG_EDGE, 32'h0000_FFFD);
    bus_wr(REG_MASK, 32'h0003_0000);
    far.set_pin(1, 1'b1);
    repeat (8) @(posedge clk);
    bus_rd(REG_STATUS); `CHK(d, 32'h0, "wrong edge seen")
    bus_wr(REG_CTRL, CTRL_RESET | 32'h0000_0100);
    bus_wr(REG_POWER, 32'h1);
    `CHK({pst, dpwr, osc}, 5'h08, "sleep entry, slow clock off")
    far.set_pin(1, 1'b0);
    wait_state(3'h1, 10);
    `CHK({pst, irq, osc}, 5'h07, "pin wake, slow clock back")
    far.set_pin(0, 1'b1);
    repeat (8) @(posedge clk);
    bus_rd(REG_STATUS); `CHK(d, 32'h0003_0000, "pin flags")
    bus_wr(REG_STATUS, 32'h0003_0000);
    `CHK(irq, 1'b0, "flag clear")
    $display("test pin done");
  endtask
  task automatic t_deep();
    bus_wr(REG_MASK, 32'h0000_0004);
    bus_wr(REG_POWER, 32'h2);
    `CHK({pst, osc, dpwr, bor, pce}, 7'h43, "deep entry")
    far.set_comp(1'b1);
    repeat (10) @(posedge clk);
    `CHK({pst, irq}, 4'h9, "comparator must not end deep")
    far.reset_pin(4);
    wait_state(3'h1, 12);
    `CHK(pst, 3'h1, "reset pin wake")
    bus_wr(REG_POWER, 32'h1);
    `CHK(pst, 3'h1, "sleep refused while pending")
    bus_wr(REG_STATUS, 32'h4);
    far.set_pin(0, 1'b0);
    bus_wr(REG_MASK, 32'h0001_0000);
    bus_wr(REG_POWER, 32'h2);
    far.set_pin(0, 1'b1);
    wait_state(3'h1, 12);
    `CHK({pst, irq}, 4'h3, "pin event ends deep")
    bus_wr(REG_STATUS, 32'h0001_0000);
    bus_wr(REG_MASK, 32'h0);
    $display("test deep done");
  endtask
  task automatic t_pulse();
    bus_wr(REG_PC_TARGET, 32'h0000_0002);
    bus_wr(REG_CTRL, CTRL_RESET | 32'h0000_4000);
    bus_wr(REG_MASK, 32'h0000_0008);
    far.pulse(0, 2);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b1, "pulse match")
    far.pulse(0, 1);
    bus_rd(REG_PC_COUNT); `CHK(d[15:0], 16'h0003, "counts on")
    bus_wr(REG_STATUS, 32'h8);
    $display("test pulse done");
  endtask
  task automatic t_timer();
    bus_wr(REG_MASK, 32'h0000_0001);
    bus_wr(REG_T0_CMP_LO, 32'h2);
    bus_wr(REG_CTRL, CTRL_RESET | 32'h0000_5000);
    bus_wr(REG_POWER, 32'h1);
    `CHK({pst, osc}, 4'h5, "sleep with slow clock")
    wait_state(3'h1, 8000);
    `CHK(irq, 1'b1, "timer wake")
    repeat (4000) @(posedge clk);
    bus_rd(REG_T0_CNT_LO); `CHK(d, 32'h3, "timer keeps running")
    $display("test timer done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_flicker();
    t_pin();
    t_deep();
    t_pulse();
    t_timer();
    stop_test();
  end
  initial begin
    #(40000 * 8);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
